// File: include/adcc_pkg.sv
// Constants, encodings and state types for the converter control block.
// Assumes byte-wide data-memory register access and a 50 MHz system clock.

package adcc_pkg;

	// ==========================================================
	// Converter shape
	localparam int RES_W = 10;
	localparam int NUM_CH = 8;
	localparam int CONV_CLKS = 32;

	// ==========================================================
	// Register addresses in data memory
	localparam logic [7:0] ADDR_RESULT_LO = 8'h24;
	localparam logic [7:0] ADDR_RESULT_HI = 8'h25;
	localparam logic [7:0] ADDR_CTRL = 8'h26;
	localparam logic [7:0] ADDR_CLKSET = 8'h27;

	// ==========================================================
	// Control register fields
	localparam int CH_LSB = 0;
	localparam int CH_W = 3;
	localparam int PCR_LSB = 3;
	localparam int PCR_W = 3;
	localparam int EOC_BIT = 6;
	localparam int START_BIT = 7;
	localparam logic [7:0] CTRL_RESET = 8'h40;

	// ==========================================================
	// Clock setting register fields
	localparam int CLK_SEL_LSB = 0;
	localparam int CLK_SEL_W = 2;
	localparam int CLK_TEST_BIT = 7;
	localparam logic [7:0] CLKSET_RESET = 8'h00;
	localparam logic [7:0] CLKSET_WR_MASK = 8'h83;
	localparam logic [1:0] CLK_DIV2 = 2'h0;
	localparam logic [1:0] CLK_DIV8 = 2'h1;
	localparam logic [1:0] CLK_DIV32 = 2'h2;
	localparam logic [5:0] DIV2_CNT = 6'h02;
	localparam logic [5:0] DIV8_CNT = 6'h08;
	localparam logic [5:0] DIV32_CNT = 6'h20;

	// ==========================================================
	// Result layout, low byte holds the two least bits on top
	localparam int LO_RES_LSB = 6;
	localparam int HI_RES_LSB = 2;

	// ==========================================================
	// State types
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_CONV
	} adcc_state_t;

	typedef enum logic [1:0] {
		SAR_IDLE,
		SAR_SAMPLE,
		SAR_BITS
	} adcc_sar_state_t;

endpackage

// File: src/adcc_conversion_control.sv
// Converter control: result, control and clock setting registers,
// start handshake and port line configuration.
// Assumes a byte-wide data-memory port and an external comparator.
//
// Operation
// R1 - Eight selectable analog inputs, 10-bit result for the chosen one.
// R2 - Both result bytes are read-only; writes leave them unchanged.
// R3 - Control bits 2..0 pick the analog input to convert.
// R4 - Control bits 5..3 decide which port B lines are analog.
// R5 - Analog lines lose digital function and pull-high; converter powered.
// R6 - All three configuration bits zero keeps the converter powered off.
// R7 - Control bit 6 is the done flag, cleared when conversion ends.
// R8 - Start bit rising resets converter and sets the done flag.
// R9 - Start bit falling after a rise begins the conversion.
// R10 - Software keeps start low until the done flag clears.
// R11 - Each finished conversion raises the interrupt request.
// R12 - Clock bits 1..0 pick system clock divided by 2, 8 or 32.
// R13 - Clock register bits 2..6 read back as zero.
// R14 - Software leaves clock register bit 7 alone.
// R15 - After configuration change, software pulses start within 10 cycles.
// R16 - No start pulse needed when configuration bits are all zero.
// R17 - Result left-justified: high byte bits 9..2, low byte top bits 1..0.
// R18 - Both result bytes load together with the done flag clearing.

`timescale 1ns/1ps

module adcc_conversion_control #(
	parameter int RES_W = adcc_pkg::RES_W,
	parameter int NUM_CH = adcc_pkg::NUM_CH,
	parameter int CONV_CLKS = adcc_pkg::CONV_CLKS
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic [7:0] addr_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wr_data_in,
	input wire logic rd_en_in,
	output logic [7:0] rd_data_out,
	input wire logic cmp_in,
	output logic [RES_W-1:0] trial_out,
	output logic sample_out,
	output logic [adcc_pkg::CH_W-1:0] channel_sel_out,
	output logic [NUM_CH-1:0] port_b_analog_out,
	output logic converter_power_out,
	output logic test_mode_out,
	output logic irq_set_out
);

	// ==========================================================
	// Port configuration decode
	// Code n makes lines 0..n-1 analog, except code 7 takes all eight.
	function automatic logic [NUM_CH-1:0] pcr_mask(
		input logic [adcc_pkg::PCR_W-1:0] pcr
	);
		pcr_mask = '0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (i < int'(pcr) || pcr == '1) begin
				pcr_mask[i] = 1'b1;
			end
		end
	endfunction

	// ==========================================================
	// State
	adcc_pkg::adcc_state_t state_r, state_nxt;
	logic [7:0] ctrl_r, ctrl_nxt;
	logic [7:0] clkset_r, clkset_nxt;
	logic [7:0] res_hi_r, res_hi_nxt;
	logic [7:0] res_lo_r, res_lo_nxt;
	logic [7:0] rd_data_r, rd_data_nxt;
	logic [NUM_CH-1:0] analog_r, analog_nxt;
	logic power_r, power_nxt;
	logic irq_r, irq_nxt;

	logic wr_ctrl;
	logic wr_clkset;
	logic start_old;
	logic start_new;
	logic start_rise;
	logic start_fall;
	logic [adcc_pkg::PCR_W-1:0] pcr_cur;
	logic power_on;
	logic sar_go;
	logic sar_abort;
	logic sar_done;
	logic sar_busy;
	logic [RES_W-1:0] sar_result;

	// ==========================================================
	// Write strobes and start edges
	assign wr_ctrl = wr_en_in && (addr_in == adcc_pkg::ADDR_CTRL);
	assign wr_clkset = wr_en_in && (addr_in == adcc_pkg::ADDR_CLKSET);
	assign start_old = ctrl_r[adcc_pkg::START_BIT];
	assign start_new = wr_data_in[adcc_pkg::START_BIT];
	assign start_rise = wr_ctrl && start_new && !start_old;
	assign start_fall = wr_ctrl && !start_new && start_old;
	assign pcr_cur = ctrl_r[adcc_pkg::PCR_LSB +: adcc_pkg::PCR_W];
	assign power_on = |pcr_mask(pcr_cur); // see R6

	// Rising start or power loss throws away a conversion in flight
	assign sar_abort = start_rise || !power_on; // see R8

	// ==========================================================
	// Control register and start sequencing
	always_comb begin
		state_nxt = state_r;
		ctrl_nxt = ctrl_r;
		res_hi_nxt = res_hi_r;
		res_lo_nxt = res_lo_r;
		irq_nxt = 1'b0;
		sar_go = 1'b0;
		if (wr_ctrl) begin
			// Done flag is owned by hardware, software writes skip it
			ctrl_nxt[adcc_pkg::START_BIT] = start_new;
			ctrl_nxt[adcc_pkg::PCR_LSB +: adcc_pkg::PCR_W] =
				wr_data_in[adcc_pkg::PCR_LSB +: adcc_pkg::PCR_W]; // see R4
			ctrl_nxt[adcc_pkg::CH_LSB +: adcc_pkg::CH_W] =
				wr_data_in[adcc_pkg::CH_LSB +: adcc_pkg::CH_W]; // see R3
		end
		case (state_r)
			adcc_pkg::ST_IDLE: begin
				if (start_rise) begin
					state_nxt = adcc_pkg::ST_ARMED;
				end
			end
			adcc_pkg::ST_ARMED: begin
				if (start_fall) begin
					if (power_on) begin
						state_nxt = adcc_pkg::ST_CONV;
						sar_go = 1'b1; // see R9
					end else begin
						state_nxt = adcc_pkg::ST_IDLE;
					end
				end
			end
			adcc_pkg::ST_CONV: begin
				// Relies on start staying low meanwhile, see R10
				if (start_rise) begin
					state_nxt = adcc_pkg::ST_ARMED;
				end else if (sar_done) begin
					state_nxt = adcc_pkg::ST_IDLE;
					ctrl_nxt[adcc_pkg::EOC_BIT] = 1'b0; // see R7
					res_hi_nxt = sar_result[RES_W-1:adcc_pkg::HI_RES_LSB];
					res_lo_nxt = '0;
					res_lo_nxt[7:adcc_pkg::LO_RES_LSB] =
						sar_result[adcc_pkg::HI_RES_LSB-1:0]; // see R17
					// Both bytes load in this one cycle, see R18
					irq_nxt = 1'b1; // see R11
				end else if (!power_on || !sar_busy) begin
					state_nxt = adcc_pkg::ST_IDLE;
				end
			end
			default: state_nxt = adcc_pkg::ST_IDLE;
		endcase
		// Rise wins over a completion landing in the same cycle
		if (start_rise) begin
			ctrl_nxt[adcc_pkg::EOC_BIT] = 1'b1; // see R8
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			state_r <= adcc_pkg::ST_IDLE;
			ctrl_r <= adcc_pkg::CTRL_RESET;
			res_hi_r <= 8'h00;
			res_lo_r <= 8'h00;
			irq_r <= 1'b0;
		end else if (ce_in) begin
			state_r <= state_nxt;
			ctrl_r <= ctrl_nxt;
			res_hi_r <= res_hi_nxt;
			res_lo_r <= res_lo_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ==========================================================
	// Clock setting register
	always_comb begin
		clkset_nxt = clkset_r;
		if (wr_clkset) begin
			// Unused bits never store, so they read as zero, see R13
			clkset_nxt = wr_data_in & adcc_pkg::CLKSET_WR_MASK;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			clkset_r <= adcc_pkg::CLKSET_RESET;
		end else if (ce_in) begin
			clkset_r <= clkset_nxt;
		end
	end

	// ==========================================================
	// Port B line configuration and converter power
	always_comb begin
		analog_nxt = pcr_mask(pcr_cur); // see R5
		power_nxt = power_on; // see R6
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			analog_r <= '0;
			power_r <= 1'b0;
		end else if (ce_in) begin
			analog_r <= analog_nxt;
			power_r <= power_nxt;
		end
	end

	// ==========================================================
	// Register read port
	// Result bytes have no write path at all, see R2
	always_comb begin
		rd_data_nxt = rd_data_r;
		if (rd_en_in) begin
			if (addr_in == adcc_pkg::ADDR_RESULT_LO) begin
				rd_data_nxt = res_lo_r;
			end else if (addr_in == adcc_pkg::ADDR_RESULT_HI) begin
				rd_data_nxt = res_hi_r;
			end else if (addr_in == adcc_pkg::ADDR_CTRL) begin
				rd_data_nxt = ctrl_r;
			end else if (addr_in == adcc_pkg::ADDR_CLKSET) begin
				rd_data_nxt = clkset_r;
			end else begin
				rd_data_nxt = 8'h00;
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			rd_data_r <= 8'h00;
		end else if (ce_in) begin
			rd_data_r <= rd_data_nxt;
		end
	end

	// ==========================================================
	// Conversion engine
	adcc_sar #(
		.RES_W(RES_W),
		.CONV_CLKS(CONV_CLKS)
	) u_sar (
		.sys_clk_in(sys_clk_in),
		.resetn_in(resetn_in),
		.ce_in(ce_in),
		.clk_sel_in(clkset_r[adcc_pkg::CLK_SEL_LSB +:
			adcc_pkg::CLK_SEL_W]), // see R12
		.go_in(sar_go),
		.abort_in(sar_abort),
		.cmp_in(cmp_in),
		.trial_out(trial_out), // see R1
		.sample_out(sample_out),
		.busy_out(sar_busy),
		.done_out(sar_done),
		.result_out(sar_result)
	);

	// ==========================================================
	// Outputs
	assign rd_data_out = rd_data_r;
	assign channel_sel_out = ctrl_r[adcc_pkg::CH_LSB +: adcc_pkg::CH_W];
	assign port_b_analog_out = analog_r;
	assign converter_power_out = power_r;
	// Test bit is only passed on; software must leave it clear, see R14
	assign test_mode_out = clkset_r[adcc_pkg::CLK_TEST_BIT];
	assign irq_set_out = irq_r;

endmodule

// File: src/adcc_sar.sv
// Converter clock divider and successive approximation sequencer.
// Assumes an external comparator that answers within one converter clock.

`timescale 1ns/1ps

module adcc_sar #(
	parameter int RES_W = adcc_pkg::RES_W,
	parameter int CONV_CLKS = adcc_pkg::CONV_CLKS
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic [1:0] clk_sel_in,
	input wire logic go_in,
	input wire logic abort_in,
	input wire logic cmp_in,
	output logic [RES_W-1:0] trial_out,
	output logic sample_out,
	output logic busy_out,
	output logic done_out,
	output logic [RES_W-1:0] result_out
);

	localparam int SAMPLE_CLKS = CONV_CLKS - RES_W;
	localparam int STEP_W = $clog2(CONV_CLKS);
	localparam int BIT_W = $clog2(RES_W);

	// ==========================================================
	// Divider select
	function automatic logic [5:0] div_limit(input logic [1:0] sel);
		case (sel)
			adcc_pkg::CLK_DIV2: div_limit = adcc_pkg::DIV2_CNT;
			adcc_pkg::CLK_DIV8: div_limit = adcc_pkg::DIV8_CNT;
			// Undefined code falls back to the slowest clock, the safe one
			default: div_limit = adcc_pkg::DIV32_CNT;
		endcase
	endfunction

	adcc_pkg::adcc_sar_state_t state_r, state_nxt;
	logic [5:0] div_r, div_nxt;
	logic [STEP_W-1:0] step_r, step_nxt;
	logic [BIT_W-1:0] bit_r, bit_nxt;
	logic [RES_W-1:0] trial_r, trial_nxt;
	logic [RES_W-1:0] result_r, result_nxt;
	logic done_r, done_nxt;
	logic tick;

	assign tick = (div_r == div_limit(clk_sel_in) - 6'h01);

	// ==========================================================
	// Sequencer
	always_comb begin
		logic [RES_W-1:0] trial_v;
		trial_v = trial_r;
		state_nxt = state_r;
		step_nxt = step_r;
		bit_nxt = bit_r;
		trial_nxt = trial_r;
		result_nxt = result_r;
		done_nxt = 1'b0;
		div_nxt = tick ? 6'h00 : div_r + 6'h01;
		if (abort_in) begin
			state_nxt = adcc_pkg::SAR_IDLE;
			div_nxt = 6'h00;
		end else begin
			case (state_r)
				adcc_pkg::SAR_IDLE: begin
					div_nxt = 6'h00;
					if (go_in) begin
						state_nxt = adcc_pkg::SAR_SAMPLE;
						step_nxt = '0;
						trial_nxt = '0;
					end
				end
				adcc_pkg::SAR_SAMPLE: begin
					if (tick) begin
						if (step_r == STEP_W'(SAMPLE_CLKS - 1)) begin
							state_nxt = adcc_pkg::SAR_BITS;
							bit_nxt = BIT_W'(RES_W - 1);
							trial_nxt = '0;
							trial_nxt[RES_W-1] = 1'b1;
						end else begin
							step_nxt = step_r + 1'b1;
						end
					end
				end
				adcc_pkg::SAR_BITS: begin
					if (tick) begin
						if (!cmp_in) begin
							trial_v[bit_r] = 1'b0;
						end
						if (bit_r == '0) begin
							result_nxt = trial_v;
							done_nxt = 1'b1;
							state_nxt = adcc_pkg::SAR_IDLE;
						end else begin
							trial_v[bit_r - 1'b1] = 1'b1;
							bit_nxt = bit_r - 1'b1;
						end
						trial_nxt = trial_v;
					end
				end
				default: state_nxt = adcc_pkg::SAR_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (!resetn_in) begin
			state_r <= adcc_pkg::SAR_IDLE;
			div_r <= 6'h00;
			step_r <= '0;
			bit_r <= '0;
			trial_r <= '0;
			result_r <= '0;
			done_r <= 1'b0;
		end else if (ce_in) begin
			state_r <= state_nxt;
			div_r <= div_nxt;
			step_r <= step_nxt;
			bit_r <= bit_nxt;
			trial_r <= trial_nxt;
			result_r <= result_nxt;
			done_r <= done_nxt;
		end
	end

	assign trial_out = trial_r;
	assign sample_out = (state_r == adcc_pkg::SAR_SAMPLE);
	assign busy_out = (state_r != adcc_pkg::SAR_IDLE);
	assign done_out = done_r;
	assign result_out = result_r;

endmodule

// File: verif/adc_conversion_control_test.sv
// Self-checking bench for the converter control block.
// Assumes the package and design are compiled first.
`timescale 1ns/1ps
module adc_conversion_control_test;
	// ==========================================================
	// Ports and bench state
	logic sys_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic ce_in = 1'b1;
	logic [7:0] addr_in = 8'h00;
	logic wr_en_in = 1'b0;
	logic [7:0] wr_data_in = 8'h00;
	logic rd_en_in = 1'b0;
	logic cmp_in = 1'b0;
	logic [7:0] rd_data_out, port_b_analog_out;
	logic [9:0] trial_out;
	logic [2:0] channel_sel_out;
	logic sample_out, converter_power_out, test_mode_out, irq_set_out;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	int irq_n = 0;
	int q;
	logic [9:0] level [8] = '{10'h3FF, 10'h000, 10'h155, 10'h2AA,
		10'h001, 10'h200, 10'h1FF, 10'h0C3};

	adcc_conversion_control u_dut (
		.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
		.addr_in(addr_in), .wr_en_in(wr_en_in), .wr_data_in(wr_data_in),
		.rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .cmp_in(cmp_in),
		.trial_out(trial_out), .sample_out(sample_out),
		.channel_sel_out(channel_sel_out),
		.port_b_analog_out(port_b_analog_out),
		.converter_power_out(converter_power_out),
		.test_mode_out(test_mode_out), .irq_set_out(irq_set_out)
	);

	always #10 sys_clk_in = ~sys_clk_in;
	// Comparator stand-in: one fixed level per analog input
	always @(posedge sys_clk_in) cmp_in <= level[channel_sel_out] >= trial_out;
	always @(posedge sys_clk_in) begin
		cycles++;
		if (irq_set_out === 1'b1) irq_n++;
		if (cycles > 20000) begin
			fail_count++;
			conclude();
		end
	end

	// ==========================================================
	// Access and compare tasks
	task automatic conclude();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		addr_in <= a;
		wr_data_in <= d;
		wr_en_in <= 1'b1;
		@(posedge sys_clk_in);
		wr_en_in <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk_in);
		addr_in <= a;
		rd_en_in <= 1'b1;
		@(posedge sys_clk_in);
		rd_en_in <= 1'b0;
		#1 chk({8'h00, rd_data_out}, {8'h00, e});
	endtask
	task automatic convert(input logic [1:0] cs, input logic [2:0] c);
		int n;
		int dv;
		int q0;
		n = 1;
		q0 = irq_n;
		dv = (cs == 2'h0) ? 2 : (cs == 2'h1) ? 8 : 32;
		wr(8'h27, {6'h00, cs});
		wr(8'h26, {2'h2, 3'h7, c});
		rchk(8'h26, {2'h3, 3'h7, c});
		wr(8'h26, {2'h1, 3'h7, c});
		@(posedge sys_clk_in);
		#1 chk({15'h0000, sample_out}, 16'h0001);
		while (irq_set_out !== 1'b1 && n < 2000) begin
			@(posedge sys_clk_in);
			#1 n++;
		end
		chk({15'h0000, n >= 32 * dv && n <= 34 * dv + 4}, 16'h0001);
		rchk(8'h26, {2'h0, 3'h7, c});
		rchk(8'h25, level[c][9:2]);
		rchk(8'h24, {level[c][1:0], 6'h00});
		chk(16'(irq_n - q0), 16'h0001);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		rchk(8'h26, 8'h40);
		rchk(8'h27, 8'h00);
		rchk(8'h25, 8'h00);
		wr(8'h27, 8'h7F);
		rchk(8'h27, 8'h03);
		chk({15'h0000, test_mode_out}, 16'h0000);
		for (int p = 0; p < 8; p++) begin
			wr(8'h26, {2'h0, p[2:0], 3'h5});
			// Mask and power settle one edge after the control write
			@(posedge sys_clk_in);
			#1 chk({8'h00, port_b_analog_out},
				(p == 7) ? 16'h00FF : (16'h0001 << p) - 16'h0001);
			chk({15'h0000, converter_power_out}, {15'h0000, p != 0});
			chk({13'h0000, channel_sel_out}, 16'h0005);
		end
		convert(2'h0, 3'h0);
		convert(2'h0, 3'h2);
		convert(2'h1, 3'h5);
		convert(2'h3, 3'h1);
		convert(2'h2, 3'h7);
		wr(8'h24, 8'hFF);
		wr(8'h25, 8'h00);
		rchk(8'h25, level[7][9:2]);
		rchk(8'h24, {level[7][1:0], 6'h00});
		wr(8'h30, 8'hFF);
		rchk(8'h30, 8'h00);
		// Dropping the configuration mid-run must abandon the conversion
		wr(8'h27, 8'h00);
		wr(8'h26, 8'h99);
		wr(8'h26, 8'h19);
		repeat (10) @(posedge sys_clk_in);
		q = irq_n;
		wr(8'h26, 8'h01);
		@(posedge sys_clk_in);
		#1 chk({15'h0000, converter_power_out}, 16'h0000);
		repeat (100) @(posedge sys_clk_in);
		chk(16'(irq_n - q), 16'h0000);
		rchk(8'h26, 8'h41);
		conclude();
	end
endmodule

// File: verif/adcc_ctrl_props.sv
// Port checker for the converter control block.
// Assumes ce_in stays high while conversions are timed.
`timescale 1ns/1ps
module adcc_ctrl_props #(
	parameter int RES_W = 10,
	parameter int NUM_CH = 8,
	parameter int CONV_CLKS = 32
) (
	input wire logic sys_clk_in,
	input wire logic resetn_in,
	input wire logic ce_in,
	input wire logic [7:0] addr_in,
	input wire logic wr_en_in,
	input wire logic [7:0] wr_data_in,
	input wire logic rd_en_in,
	input wire logic [7:0] rd_data_out,
	input wire logic cmp_in,
	input wire logic [RES_W-1:0] trial_out,
	input wire logic sample_out,
	input wire logic [adcc_pkg::CH_W-1:0] channel_sel_out,
	input wire logic [NUM_CH-1:0] port_b_analog_out,
	input wire logic converter_power_out,
	input wire logic test_mode_out,
	input wire logic irq_set_out
);
	// ==========================================================
	// Helper state: stored start bit, divider, cycles since go
	logic start_r, start_nxt;
	logic [1:0] sel_r, sel_nxt;
	logic [2:0] pcr_r, pcr_nxt;
	logic [11:0] cnt_r, cnt_nxt;
	logic [5:0] divv;
	logic wr_ctrl, rd_ok;
	assign wr_ctrl = ce_in && wr_en_in && addr_in == adcc_pkg::ADDR_CTRL;
	assign rd_ok = ce_in && rd_en_in;
	assign divv = (sel_r == 2'h0) ? 6'h02 : (sel_r == 2'h1) ? 6'h08 : 6'h20;
	function automatic logic [7:0] mask_of(input logic [2:0] p);
		return (p == 3'h7) ? 8'hFF : (8'h01 << p) - 8'h01;
	endfunction
	always_comb begin
		start_nxt = wr_ctrl ? wr_data_in[7] : start_r;
		// Stored config decides a fall, not the one written with it
		pcr_nxt = wr_ctrl ? wr_data_in[5:3] : pcr_r;
		sel_nxt = sel_r;
		// Saturate so a long idle never wraps into a false match
		cnt_nxt = (cnt_r == 12'hFFF) ? cnt_r : cnt_r + 12'h001;
		if (wr_ctrl && start_r && !wr_data_in[7]) cnt_nxt = 12'h000;
		if (ce_in && wr_en_in && addr_in == adcc_pkg::ADDR_CLKSET)
			sel_nxt = wr_data_in[1:0];
	end
	always_ff @(posedge sys_clk_in) begin
		start_r <= resetn_in ? start_nxt : 1'b0;
		pcr_r <= resetn_in ? pcr_nxt : 3'h0;
		sel_r <= resetn_in ? sel_nxt : 2'h0;
		cnt_r <= resetn_in ? cnt_nxt : 12'hFFF;
	end
	// ==========================================================
	// Assertions
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!resetn_in);
	chan_select_a: assert property (wr_ctrl |=>
		channel_sel_out == $past(wr_data_in[2:0])) else $error("channel mismatch");
	port_mask_a: assert property (wr_ctrl |-> ##2
		port_b_analog_out == mask_of($past(wr_data_in[5:3], 2)))
		else $error("port mask mismatch");
	power_tie_a: assert property (
		converter_power_out == (port_b_analog_out != 8'h00))
		else $error("power does not follow mask");
	go_sample_a: assert property (wr_ctrl && start_r && !wr_data_in[7] &&
		pcr_r != 3'h0 |=> sample_out) else $error("no sampling");
	irq_pulse_a: assert property (irq_set_out |=> !irq_set_out)
		else $error("irq longer than one cycle");
	conv_length_a: assert property (irq_set_out |->
		cnt_r >= {6'h00, divv} * 12'h01E &&
		cnt_r <= {6'h00, divv} * 12'h022 + 12'h004) else $error("bad length");
	low_pad_a: assert property (rd_ok && addr_in == adcc_pkg::ADDR_RESULT_LO
		|=> rd_data_out[5:0] == 6'h00) else $error("low byte pad set");
	clk_unused_a: assert property (rd_ok && addr_in == adcc_pkg::ADDR_CLKSET
		|=> rd_data_out[6:2] == 5'h00) else $error("clock bits not zero");
	test_bit_a: assert property (ce_in && wr_en_in &&
		addr_in == adcc_pkg::ADDR_CLKSET |=> test_mode_out == $past(wr_data_in[7]))
		else $error("test bit mismatch");
	unmapped_a: assert property (rd_ok && addr_in[7:2] != 6'h09
		|=> rd_data_out == 8'h00) else $error("unmapped read not zero");
	cover property (irq_set_out);
	cover property ($rose(sample_out));
	cover property (wr_ctrl && wr_data_in[7]);
endmodule

bind adcc_conversion_control adcc_ctrl_props #(
	.RES_W(RES_W), .NUM_CH(NUM_CH), .CONV_CLKS(CONV_CLKS)
) u_props (
	.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
	.addr_in(addr_in), .wr_en_in(wr_en_in), .wr_data_in(wr_data_in),
	.rd_en_in(rd_en_in), .rd_data_out(rd_data_out), .cmp_in(cmp_in),
	.trial_out(trial_out), .sample_out(sample_out),
	.channel_sel_out(channel_sel_out), .port_b_analog_out(port_b_analog_out),
	.converter_power_out(converter_power_out),
	.test_mode_out(test_mode_out), .irq_set_out(irq_set_out)
);
